// [inc/olt_pkg.sv]
// Purpose: shared constants for the overload current limit timer
// Assumes: 250 MHz mclk, synchronous comparator inputs
// Notes: times kept in ns, cycle counts derived from the clock rate
package olt_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_BURST_NS = 45000;
    localparam int T_HOLD_NS = 630000;
    localparam int BURST_CYC = T_BURST_NS / CLK_PERIOD_NS;
    localparam int HOLD_CYC = T_HOLD_NS / CLK_PERIOD_NS;
    // limit pin source codes, unit is 2.5 uA
    // 20 uA does not fit three bits, so code 0 stands for the doubled source
    localparam logic [2:0] SRC_QUARTER = 3'h1;
    localparam logic [2:0] SRC_NORMAL = 3'h4;
    localparam logic [2:0] SRC_DOUBLE = 3'h0;
    typedef enum logic [2:0] {
        OLT_BOOT = 3'b000,
        OLT_NORMAL = 3'b001,
        OLT_BURST1 = 3'b010,
        OLT_BURST2 = 3'b011,
        OLT_HOLD1X = 3'b100,
        OLT_LIMIT = 3'b101,
        OLT_LATCH = 3'b110
    } olt_state_t;
    localparam int ST_BITS = 3;
    localparam logic [7:0] IRQ_LIMIT_BIT = 8'h01;
endpackage

// [tb/olt_sense_model.sv]
// Purpose: behavioural current comparator and switching clock
// Assumes: load level from the bench, 0 none, 1 above 1x, 2 above 2x
// Notes: level based, so the bench can hold an overload across cycles
module olt_sense_model #(
    parameter int PERIOD = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] load_level,
    output logic over_1x,
    output logic over_2x,
    output logic cycle_start
);
    timeunit 1ns;
    timeprecision 1ps;
    int phase;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 0;
            cycle_start <= 1'b0;
        end
        else
        begin
            phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
            cycle_start <= (phase == 0);
        end
    end
    // above 2x always implies above 1x
    assign over_1x = (load_level != 2'h0);
    assign over_2x = (load_level == 2'h2);
endmodule

// [tb/overload_current_limit_timer_tb.sv]
// Purpose: self-checking bench for the overload current limit timer
// Assumes: short windows, burst 8 and hold 40 cycles
// Notes: each scenario starts from a fresh reset
module overload_current_limit_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BURST = 8;
    localparam int HOLD = 40;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] load_level = 2'h0;
    logic boot_voltage_level = 1'b0;
    logic ref_slewing = 1'b0;
    logic output_good_flag = 1'b1;
    logic soft_start_low = 1'b0;
    logic low_output_fault = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic over_1x, over_2x, cycle_start;
    logic [7:0] rdata, rv;
    logic [2:0] limit_source_code;
    logic top_gate_drive, soft_start_discharge, switcher_off, irq;
    int bad_count = 0;
    int checks = 0;
    int n;

    always #2 mclk = ~mclk;

    olt_sense_model sense (.mclk(mclk), .rst_n(rst_n),
        .load_level(load_level), .over_1x(over_1x), .over_2x(over_2x),
        .cycle_start(cycle_start));
    olt_core #(.BURST_CYCLES(BURST), .HOLD_CYCLES(HOLD)) dut (
        .mclk(mclk), .rst_n(rst_n), .over_1x(over_1x), .over_2x(over_2x),
        .boot_voltage_level(boot_voltage_level), .ref_slewing(ref_slewing),
        .output_good_flag(output_good_flag),
        .soft_start_low(soft_start_low), .low_output_fault(low_output_fault),
        .cycle_start(cycle_start), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .limit_source_code(limit_source_code),
        .top_gate_drive(top_gate_drive),
        .soft_start_discharge(soft_start_discharge),
        .switcher_off(switcher_off), .irq(irq));

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [1:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic wait_src(input logic [2:0] code, input int lim);
        n = 0;
        while (limit_source_code !== code && n < lim)
        begin
            tick(1);
            n++;
        end
        check("source code", limit_source_code, code);
        if (limit_source_code !== code)
            stop_test();
    endtask

    task automatic wait_state(input logic [2:0] st, input int lim);
        int k;
        k = 0;
        reg_rd(2'h2);
        while (rv[2:0] !== st && k < lim)
        begin
            reg_rd(2'h2);
            k++;
        end
        check("state", rv[2:0], st);
        if (rv[2:0] !== st)
            stop_test();
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        load_level <= 2'h0;
        ref_slewing <= 1'b0;
        soft_start_low <= 1'b0;
        low_output_fault <= 1'b0;
        output_good_flag <= 1'b1;
        boot_voltage_level <= 1'b0;
        tick(3);
        check("reset source", limit_source_code, olt_pkg::SRC_NORMAL);
        check("reset outputs", {top_gate_drive, soft_start_discharge,
            switcher_off, irq}, 8'h00);
        @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    task automatic boot();
        @(posedge mclk);
        boot_voltage_level <= 1'b1;
        tick(3);
        reg_wr(2'h0, 8'h07);
        reg_wr(2'h1, 8'h07);
    endtask

    task automatic t_boot();
        do_reset();
        @(posedge mclk);
        load_level <= 2'h1;
        ref_slewing <= 1'b1;
        tick(4);
        check("pre-boot", limit_source_code, olt_pkg::SRC_NORMAL);
        @(posedge mclk);
        load_level <= 2'h0;
        boot_voltage_level <= 1'b1;
        wait_src(olt_pkg::SRC_DOUBLE, 4);
        @(posedge mclk);
        ref_slewing <= 1'b0;
        wait_src(olt_pkg::SRC_NORMAL, 4);
    endtask

    task automatic pulse_load(input int k);
        @(posedge mclk);
        load_level <= 2'h1;
        tick(k);
        @(posedge mclk);
        load_level <= 2'h0;
        tick(4);
    endtask

    // three short overloads inside the hold window, then irq handling
    task automatic t_short();
        do_reset();
        boot();
        @(posedge mclk);
        load_level <= 2'h1;
        wait_src(olt_pkg::SRC_DOUBLE, 4);
        @(posedge mclk);
        load_level <= 2'h0;
        tick(4);
        pulse_load(3);
        reg_rd(2'h0);
        check("second tolerated", rv[0], 1'b0);
        pulse_load(3);
        reg_rd(2'h0);
        check("third limits", rv[0], 1'b1);
        check("irq raised", irq, 1'b1);
        reg_wr(2'h1, 8'h00);
        tick(2);
        check("irq masked", irq, 1'b0);
        reg_wr(2'h1, 8'h07);
        tick(2);
        check("irq unmasked", irq, 1'b1);
        reg_wr(2'h0, 8'h07);
        tick(2);
        check("irq cleared", irq, 1'b0);
        reg_rd(2'h0);
        check("status cleared", rv, 8'h00);
    endtask

    task automatic t_long();
        do_reset();
        boot();
        @(posedge mclk);
        load_level <= 2'h1;
        wait_src(olt_pkg::SRC_DOUBLE, 4);
        tick(BURST + 3);
        check("2x past 45", limit_source_code, olt_pkg::SRC_DOUBLE);
        @(posedge mclk);
        load_level <= 2'h0;
        wait_src(olt_pkg::SRC_NORMAL, 3 * BURST);
        check("2x to 90 only", n >= 2 && n <= BURST, 1'b1);
        reg_rd(2'h2);
        check("hold state", rv[2:0], 3'h4);
        tick(2);
        @(posedge mclk);
        load_level <= 2'h1;
        tick(4);
        check("1x hold", limit_source_code, olt_pkg::SRC_NORMAL);
        do_reset();
        boot();
        @(posedge mclk);
        load_level <= 2'h1;
        wait_state(3'h5, 2 * BURST);
        @(posedge mclk);
        load_level <= 2'h0;
        wait_state(3'h1, 4);
    endtask

    task automatic t_hard();
        do_reset();
        boot();
        @(posedge mclk);
        load_level <= 2'h2;
        wait_state(3'h5, 3);
        check("top gate off", top_gate_drive, 1'b0);
        check("ss drain", soft_start_discharge, 1'b1);
        @(posedge mclk);
        low_output_fault <= 1'b1;
        wait_state(3'h6, 4);
        @(posedge mclk);
        load_level <= 2'h0;
        low_output_fault <= 1'b0;
        tick(4);
        check("latched off", switcher_off, 1'b1);
        reg_rd(2'h0);
        check("latch status", rv[1], 1'b1);
    endtask

    task automatic t_clamp();
        do_reset();
        boot();
        @(posedge mclk);
        output_good_flag <= 1'b0;
        load_level <= 2'h1;
        tick(4);
        check("low out 1x", limit_source_code, olt_pkg::SRC_NORMAL);
        @(posedge mclk);
        load_level <= 2'h0;
        soft_start_low <= 1'b1;
        tick(3);
        check("quarter", limit_source_code, olt_pkg::SRC_QUARTER);
    endtask

    // unmapped place and read-only state register
    task automatic t_regs();
        do_reset();
        boot();
        reg_wr(2'h3, 8'hff);
        reg_rd(2'h3);
        check("unmapped", rv, 8'h00);
        reg_wr(2'h1, 8'h05);
        reg_rd(2'h1);
        check("mask", rv, 8'h05);
        reg_wr(2'h2, 8'hff);
        reg_rd(2'h2);
        check("state ro", rv, 8'h09);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        stop_test();
    end

    initial
    begin
        t_regs();
        t_boot();
        t_short();
        t_long();
        t_hard();
        t_clamp();
        stop_test();
    end
endmodule

// [verilog/olt_core.sv]
// Purpose: timed overload manager choosing 1x or 2x peak current limit
// Assumes: comparator and voltage flags synchronous to mclk
// Notes: register port reaches status, mask and the read-only state
// Functional notes
// - every cycle the peak limit is enforced with the limit pin biased.
// - after power-up the limit stays 1x until boot level is reached.
// - while the reference slews after boot the source is doubled.
// - an overload while not slewing gives 2x for 45 us.
// - an overload shorter than 45 us allows one more within 630 us.
// - a further overload in the 630 us after the second enters limit.
// - overload past 45 us extends 2x to 90 us, then 1x for 630 us.
// - load above 1x beyond 90 us or above 2x enters current limit.
// - in current limit the top gate duty drops and soft-start drains.
// - limit holds until overload clears, or low output latches off.
// - below the output-good level the threshold is held at 1x.
// - entering limit turns top gate off for the rest of the cycle.
// - soft-start below 0.3 V cuts the source to a quarter.
module olt_core #(
    parameter int BURST_CYCLES = olt_pkg::BURST_CYC,
    parameter int HOLD_CYCLES = olt_pkg::HOLD_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic over_1x,
    input wire logic over_2x,
    input wire logic boot_voltage_level,
    input wire logic ref_slewing,
    input wire logic output_good_flag,
    input wire logic soft_start_low,
    input wire logic low_output_fault,
    input wire logic cycle_start,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [2:0] limit_source_code,
    output logic top_gate_drive,
    output logic soft_start_discharge,
    output logic switcher_off,
    output logic irq
);
    localparam int TW = 20;
    localparam logic [1:0] A_STATUS = 2'h0;
    localparam logic [1:0] A_MASK = 2'h1;
    localparam logic [1:0] A_STATE = 2'h2;
    initial
    begin
        if (BURST_CYCLES < 2 || HOLD_CYCLES < 2 ||
            HOLD_CYCLES >= (1 << TW) || BURST_CYCLES >= (1 << TW))
            $error("olt_core: interval counts out of range");
    end

    olt_pkg::olt_state_t state_reg, state_next;
    logic booted_reg;
    logic tolerated_reg;
    logic ov_prev_reg;
    logic [7:0] status_reg, mask_reg;
    logic [7:0] status_ev;
    logic b_load, h_load, b_run, b_exp, h_run, h_exp;
    logic ov_rise;

    assign ov_rise = over_1x && !ov_prev_reg;

    // short window: 45 us burst timer
    olt_interval_timer #(.WIDTH(TW)) burst_tmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(b_load),
        .load_val(TW'(BURST_CYCLES)),
        .stop(1'b0),
        .running(b_run),
        .expired(b_exp)
    );
    // long window: 630 us hold timer
    olt_interval_timer #(.WIDTH(TW)) hold_tmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(h_load),
        .load_val(TW'(HOLD_CYCLES)),
        // window must keep running in normal so the next event is counted
        .stop(state_reg == olt_pkg::OLT_LIMIT),
        .running(h_run),
        .expired(h_exp)
    );

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ov_prev_reg <= 1'b0;
        else
            ov_prev_reg <= over_1x;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            booted_reg <= 1'b0;
        else if (boot_voltage_level)
            booted_reg <= 1'b1;
    end

    always_comb
    begin
        state_next = state_reg;
        b_load = 1'b0;
        h_load = 1'b0;
        unique case (state_reg)
            olt_pkg::OLT_BOOT:
                if (booted_reg)
                    state_next = olt_pkg::OLT_NORMAL;
            olt_pkg::OLT_NORMAL:
                if (ov_rise && !ref_slewing && output_good_flag)
                begin
                    if (tolerated_reg && h_run)
                        state_next = olt_pkg::OLT_LIMIT;
                    else
                    begin
                        state_next = olt_pkg::OLT_BURST1;
                        b_load = 1'b1;
                    end
                end
            olt_pkg::OLT_BURST1:
                if (!over_1x)
                begin
                    state_next = olt_pkg::OLT_NORMAL;
                    h_load = 1'b1;
                end
                else if (b_exp)
                begin
                    state_next = olt_pkg::OLT_BURST2;
                    b_load = 1'b1;
                end
            olt_pkg::OLT_BURST2:
                // 2x stays until 90 us even if the overload ends earlier
                if (b_exp)
                begin
                    state_next = over_1x ? olt_pkg::OLT_LIMIT
                                         : olt_pkg::OLT_HOLD1X;
                    h_load = !over_1x;
                end
            olt_pkg::OLT_HOLD1X:
                if (over_1x)
                    state_next = olt_pkg::OLT_LIMIT;
                else if (h_exp)
                    state_next = olt_pkg::OLT_NORMAL;
            olt_pkg::OLT_LIMIT:
                if (low_output_fault)
                    state_next = olt_pkg::OLT_LATCH;
                else if (!over_1x)
                    state_next = olt_pkg::OLT_NORMAL;
            olt_pkg::OLT_LATCH:
                state_next = olt_pkg::OLT_LATCH;
            default:
                state_next = olt_pkg::OLT_BOOT;
        endcase
        // excess above 2x enters limit from any timed state
        if (over_2x && state_reg != olt_pkg::OLT_LATCH &&
            state_reg != olt_pkg::OLT_BOOT)
            state_next = olt_pkg::OLT_LIMIT;
        if (low_output_fault && state_reg != olt_pkg::OLT_BOOT)
            state_next = olt_pkg::OLT_LATCH;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= olt_pkg::OLT_BOOT;
        else
            state_reg <= state_next;
    end

    // second tolerated event arms the third-event check
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tolerated_reg <= 1'b0;
        else if (state_reg == olt_pkg::OLT_BURST1 && !over_1x)
            tolerated_reg <= h_run;
        else if (h_exp || state_reg == olt_pkg::OLT_LIMIT)
            tolerated_reg <= 1'b0;
    end

    // source priority: soft-start low, then output-good, then 2x
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            limit_source_code <= olt_pkg::SRC_NORMAL;
        else if (soft_start_low)
            limit_source_code <= olt_pkg::SRC_QUARTER;
        else if (!output_good_flag || state_next == olt_pkg::OLT_BOOT)
            limit_source_code <= olt_pkg::SRC_NORMAL;
        else if (ref_slewing ||
                 state_next == olt_pkg::OLT_BURST1 ||
                 state_next == olt_pkg::OLT_BURST2)
            limit_source_code <= olt_pkg::SRC_DOUBLE;
        else
            limit_source_code <= olt_pkg::SRC_NORMAL;
    end

    // gate and soft-start outputs
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            top_gate_drive <= 1'b0;
            soft_start_discharge <= 1'b0;
            switcher_off <= 1'b0;
        end
        else
        begin
            switcher_off <= (state_next == olt_pkg::OLT_LATCH);
            soft_start_discharge <= (state_next == olt_pkg::OLT_LIMIT);
            if (state_next == olt_pkg::OLT_LATCH)
                top_gate_drive <= 1'b0;
            else if (state_next == olt_pkg::OLT_LIMIT &&
                     state_reg != olt_pkg::OLT_LIMIT)
                top_gate_drive <= 1'b0;
            else if (over_1x && state_next == olt_pkg::OLT_LIMIT)
                top_gate_drive <= 1'b0;
            else if (cycle_start)
                top_gate_drive <= 1'b1;
        end
    end

    always_comb
    begin
        status_ev = 8'h00;
        status_ev[0] = (state_next == olt_pkg::OLT_LIMIT) &&
                       (state_reg != olt_pkg::OLT_LIMIT);
        status_ev[1] = (state_next == olt_pkg::OLT_LATCH) &&
                       (state_reg != olt_pkg::OLT_LATCH);
        status_ev[2] = (state_next == olt_pkg::OLT_BURST1) &&
                       (state_reg != olt_pkg::OLT_BURST1);
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            status_reg <= 8'h00;
        else
            status_reg <= ((wr && addr == A_STATUS) ?
                           (status_reg & ~wdata) : status_reg) | status_ev;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mask_reg <= 8'h00;
        else if (wr && addr == A_MASK)
            mask_reg <= wdata;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(status_reg & mask_reg);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd)
        begin
            unique case (addr)
                A_STATUS: rdata <= status_reg;
                A_MASK: rdata <= mask_reg;
                A_STATE: rdata <= {3'h0, tolerated_reg, booted_reg,
                                   state_reg};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    limit_latches_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == olt_pkg::OLT_LATCH |=> state_reg == olt_pkg::OLT_LATCH)
        else $error("latched-off state left");
    boot_holds_1x_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == olt_pkg::OLT_BOOT && !booted_reg && !soft_start_low |=>
        limit_source_code == olt_pkg::SRC_NORMAL)
        else $error("boot not at 1x");
    pgood_low_1x_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !output_good_flag && !soft_start_low |=>
        limit_source_code == olt_pkg::SRC_NORMAL)
        else $error("2x while output not good");
    ss_low_quarter_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_start_low |=> limit_source_code == olt_pkg::SRC_QUARTER)
        else $error("source not cut at low soft-start");
    limit_gate_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == olt_pkg::OLT_LIMIT && !$past(state_reg ==
        olt_pkg::OLT_LIMIT) |-> !top_gate_drive && soft_start_discharge)
        else $error("limit entry left gate on");
    over2x_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        over_2x && !low_output_fault && state_reg != olt_pkg::OLT_BOOT &&
        state_reg != olt_pkg::OLT_LATCH |=>
        state_reg == olt_pkg::OLT_LIMIT)
        else $error("2x overload did not limit");
    burst_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == olt_pkg::OLT_NORMAL && ov_rise && !ref_slewing &&
        output_good_flag && !tolerated_reg && !over_2x &&
        !low_output_fault |=> state_reg == olt_pkg::OLT_BURST1)
        else $error("overload did not start 2x window");
    fault_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        low_output_fault && state_reg != olt_pkg::OLT_BOOT |=>
        state_reg == olt_pkg::OLT_LATCH ##1 switcher_off)
        else $error("low output fault not latched");
endmodule

// [verilog/olt_interval_timer.sv]
// Purpose: restartable down counter with expiry pulse
// Assumes: load wins over count
// Notes: used for the short and long overload windows
module olt_interval_timer #(
    parameter int WIDTH = 20
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic stop,
    output logic running,
    output logic expired
);
    logic [WIDTH-1:0] cnt_reg;
    initial
    begin
        if (WIDTH < 2) $error("olt_interval_timer: WIDTH too small");
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end
        else if (load)
        begin
            cnt_reg <= load_val;
            expired <= 1'b0;
        end
        else if (stop)
        begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
            if (cnt_reg != '0)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
    assign running = (cnt_reg != '0);
endmodule
